/* File: core/mco_main_clock_ctrl.sv */
// Main clock source selection, oscillator run control and stabilization wait
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

// What this block does
// (R1) Select bit 1 picks high-speed system clock
// (R2) Select bit 0 picks fast on-chip clock
// (R3) Read-only status bit 5 shows active source
// (R4) Halve on-chip output at 48 MHz only
// (R5) Software writes zero to unused select bits
// (R6) Peripherals follow CPU clock change together
// (R7) Software orders motor timer gate around switches
// (R8) Run control resets C0H, bit 6 reads 1
// (R9) Crystal stop bit runs or stops high-speed source
// (R10) On-chip stop bit runs or stops fast oscillator
// (R11) Software sets pin mode before run control
// (R12) Software sets wait select before starting crystal
// (R13) Software never stops the active oscillator
// (R14) Status cleared by reset, STOP, crystal stop
// (R15) Counter starts on crystal start or STOP release
// (R16) Flags set in order, then stay set
// (R17) Counter stops at selected wait time
// (R18) Software picks wait beyond checked count
// (R19) Wait select codes map to eight waits
// (R20) Crystal use withheld until wait elapses
// (R21) Wait select resets 07H, byte writes only
// (R22) Wait counts only real oscillator cycles
// (R23) Software polls status before switching to crystal
// (R24) Glitch-free switch, status follows real source
module mco_main_clock_ctrl (
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // Register port
  input  wire logic [mco_pkg::MCO_AW-1:0]    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // CPU and option settings
  input  wire logic                          stop_mode,
  input  wire logic                          external_clock_pin_mode,
  input  wire logic                          oscillator_pin_select,
  input  wire logic                          onchip_raw_is_48mhz,
  // Crystal input pin
  input  wire logic                          crystal_input,
  // Oscillator controls
  output logic                               crystal_osc_enable,
  output logic                               ext_clock_accept,
  output logic                               onchip_fast_osc_enable,
  output logic                               fast_osc_halve,
  // Main clock switch
  output logic                               main_clock_from_crystal,
  output logic                               main_clock_gate_en,
  output logic                               high_speed_clock_ready
);
  import mco_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                      crystal_stop_ff;
  logic                      nxt_crystal_stop;
  logic                      onchip_fast_osc_stop_ff;
  logic                      nxt_onchip_fast_osc_stop;
  logic [MCO_WAIT_SEL_W-1:0] wait_sel_ff;
  logic [MCO_WAIT_SEL_W-1:0] nxt_wait_sel;
  logic                      main_clock_select_ff;
  logic                      nxt_main_clock_select;
  logic                      main_clock_status_ff;
  logic                      nxt_main_clock_status;
  logic [7:0]                rdata_ff;
  logic [7:0]                nxt_rdata;
  logic                      halve_ff;
  logic                      ready_ff;
  logic                      nxt_ready;
  logic                      xtal_d_ff;
  mco_sw_state_t             sw_state_ff;
  mco_sw_state_t             nxt_sw_state;
  logic [1:0]                quiet_ff;
  logic [1:0]                nxt_quiet;
  logic                      gate_ff;
  logic                      nxt_gate;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_run  = (reg_addr == MCO_ADDR_RUN_CTRL);
  wire hit_sts  = (reg_addr == MCO_ADDR_STAB_STS);
  wire hit_wsel = (reg_addr == MCO_ADDR_STAB_SEL);
  wire hit_csel = (reg_addr == MCO_ADDR_CLK_SEL);
  wire wr_run   = reg_wr & hit_run;
  wire wr_wsel  = reg_wr & hit_wsel;
  wire wr_csel  = reg_wr & hit_csel;

  // ----------------------------------------------------------------
  // Pin modes and oscillator run state
  // ----------------------------------------------------------------
  wire mode_xtal    = oscillator_pin_select & ~external_clock_pin_mode;
  wire mode_ext     = oscillator_pin_select & external_clock_pin_mode;
  wire hs_pin_mode  = oscillator_pin_select;
  wire hs_running   = hs_pin_mode & ~crystal_stop_ff & ~stop_mode;          // [R9]
  wire fast_running = ~onchip_fast_osc_stop_ff & ~stop_mode;                // [R10]

  // Setting the crystal stop bit clears the status at once
  wire xstop_set    = wr_run & reg_wdata[MCO_RUN_XSTOP_BIT];
  wire stab_clear   = stop_mode | xstop_set;                                // [R14]
  wire stab_run     = mode_xtal & hs_running;                               // [R15]

  // ----------------------------------------------------------------
  // Crystal pin sampling
  // ----------------------------------------------------------------
  logic xtal_s;
  wire  xtal_tick = xtal_s & ~xtal_d_ff;

  mco_sync2 #(
    .W (1)
  ) u_xtal_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in (crystal_input),
    .sync_out (xtal_s)
  );

  logic [7:0] stab_flags;
  logic       stab_reached;

  mco_stab_counter u_stab (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .clear     (stab_clear),
    .run       (stab_run),
    .xtal_tick (xtal_tick),
    .wait_sel  (wait_sel_ff),
    .flags     (stab_flags),
    .reached   (stab_reached)
  );

  // ----------------------------------------------------------------
  // High-speed clock usable
  // ----------------------------------------------------------------
  // Crystal use is held off until the counter reaches the chosen wait
  assign nxt_ready = hs_running & (mode_ext | (mode_xtal & stab_reached & ~stab_clear)); // [R20]

  // ----------------------------------------------------------------
  // Register write paths
  // ----------------------------------------------------------------
  assign nxt_crystal_stop         = wr_run ? reg_wdata[MCO_RUN_XSTOP_BIT]
                                           : crystal_stop_ff;               // [R9]
  assign nxt_onchip_fast_osc_stop = wr_run ? reg_wdata[MCO_RUN_FSTOP_BIT]
                                           : onchip_fast_osc_stop_ff;       // [R10]
  assign nxt_wait_sel             = wr_wsel ? reg_wdata[MCO_WAIT_SEL_W-1:0]
                                            : wait_sel_ff;                  // [R21]
  // Status bit is not taken from the write data
  assign nxt_main_clock_select    = wr_csel ? reg_wdata[MCO_SEL_SELECT_BIT]
                                            : main_clock_select_ff;         // [R3]

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rd_run;
  logic [7:0] rd_wsel;
  logic [7:0] rd_csel;

  always_comb begin
    rd_run                    = MCO_RST_RUN_CTRL & 8'h40;
    rd_run[MCO_RUN_ONE_BIT]   = 1'b1;                                        // [R8]
    rd_run[MCO_RUN_XSTOP_BIT] = crystal_stop_ff;
    rd_run[MCO_RUN_FSTOP_BIT] = onchip_fast_osc_stop_ff;
    rd_wsel                   = 8'h00;
    rd_wsel[MCO_WAIT_SEL_W-1:0] = wait_sel_ff;
    rd_csel                   = 8'h00;
    rd_csel[MCO_SEL_STATUS_BIT] = main_clock_status_ff;                      // [R3]
    rd_csel[MCO_SEL_SELECT_BIT] = main_clock_select_ff;
  end

  assign nxt_rdata = !reg_rd  ? MCO_RD_UNMAPPED :
                     hit_run  ? rd_run          :
                     hit_sts  ? stab_flags      :
                     hit_wsel ? rd_wsel         :
                     hit_csel ? rd_csel         : MCO_RD_UNMAPPED;

  // ----------------------------------------------------------------
  // Glitch-free source switch
  // ----------------------------------------------------------------
  // The target must be running (crystal: stabilized) before the swap;
  // the main clock is gated off around the select change.
  wire target_ok = main_clock_select_ff ? ready_ff : fast_running;
  wire want_swap = (main_clock_select_ff != main_clock_status_ff) & target_ok;

  always_comb begin
    nxt_sw_state          = sw_state_ff;
    nxt_quiet             = quiet_ff;
    nxt_gate              = gate_ff;
    nxt_main_clock_status = main_clock_status_ff;
    unique case (sw_state_ff)
      MCO_SW_RUN: begin
        if (want_swap) begin
          nxt_gate     = 1'b0;                                               // [R24]
          nxt_quiet    = MCO_QUIET_CYC;
          nxt_sw_state = MCO_SW_QUIET;
        end
      end
      MCO_SW_QUIET: begin
        if (quiet_ff == 2'h1) begin
          nxt_sw_state = MCO_SW_SWAP;
        end
        nxt_quiet = quiet_ff - 2'h1;
      end
      MCO_SW_SWAP: begin
        // Status flips only when the new source reaches the output
        nxt_main_clock_status = ~main_clock_status_ff;                       // [R1] [R2] [R24]
        nxt_gate              = 1'b1;
        nxt_sw_state          = MCO_SW_RUN;
      end
      default: begin
        nxt_gate     = 1'b1;
        nxt_sw_state = MCO_SW_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      crystal_stop_ff         <= MCO_RST_RUN_CTRL[MCO_RUN_XSTOP_BIT];        // [R8]
      onchip_fast_osc_stop_ff <= MCO_RST_RUN_CTRL[MCO_RUN_FSTOP_BIT];
      wait_sel_ff             <= MCO_RST_STAB_SEL[MCO_WAIT_SEL_W-1:0];       // [R21]
      main_clock_select_ff    <= MCO_RST_CLK_SEL[MCO_SEL_SELECT_BIT];
      main_clock_status_ff    <= MCO_RST_CLK_SEL[MCO_SEL_STATUS_BIT];
    end else begin
      crystal_stop_ff         <= nxt_crystal_stop;
      onchip_fast_osc_stop_ff <= nxt_onchip_fast_osc_stop;
      wait_sel_ff             <= nxt_wait_sel;
      main_clock_select_ff    <= nxt_main_clock_select;
      main_clock_status_ff    <= nxt_main_clock_status;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sw_state_ff <= MCO_SW_RUN;
      quiet_ff    <= 2'h0;
      gate_ff     <= 1'b1;
      ready_ff    <= 1'b0;
      xtal_d_ff   <= 1'b0;
      rdata_ff    <= MCO_RD_UNMAPPED;
      halve_ff    <= 1'b0;
    end else begin
      sw_state_ff <= nxt_sw_state;
      quiet_ff    <= nxt_quiet;
      gate_ff     <= nxt_gate;
      ready_ff    <= nxt_ready;
      xtal_d_ff   <= xtal_s;
      rdata_ff    <= nxt_rdata;
      halve_ff    <= onchip_raw_is_48mhz;                                     // [R4]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata               = rdata_ff;
  assign crystal_osc_enable      = mode_xtal & hs_running;                    // [R9]
  assign ext_clock_accept        = mode_ext & hs_running;                     // [R9]
  assign onchip_fast_osc_enable  = fast_running;                              // [R10]
  assign fast_osc_halve          = halve_ff;                                  // [R4]
  // CPU and peripheral clocks share this select and gate
  assign main_clock_from_crystal = main_clock_status_ff;                      // [R6]
  assign main_clock_gate_en      = gate_ff;                                   // [R24]
  assign high_speed_clock_ready  = ready_ff;

endmodule

/* File: shared/mco_pkg.sv */
// Package: register map, field positions, reset values and wait table of the main clock control
package mco_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int          MCO_AW            = 20;
  localparam logic [19:0] MCO_ADDR_RUN_CTRL = 20'hFFFA1;
  localparam logic [19:0] MCO_ADDR_STAB_STS = 20'hFFFA2;
  localparam logic [19:0] MCO_ADDR_STAB_SEL = 20'hFFFA3;
  localparam logic [19:0] MCO_ADDR_CLK_SEL  = 20'hFFFA4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCO_RUN_XSTOP_BIT  = 7;
  localparam int MCO_RUN_ONE_BIT    = 6;
  localparam int MCO_RUN_FSTOP_BIT  = 0;
  localparam int MCO_SEL_STATUS_BIT = 5;
  localparam int MCO_SEL_SELECT_BIT = 4;
  localparam int MCO_WAIT_SEL_W     = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MCO_RST_RUN_CTRL = 8'hC0;
  localparam logic [7:0] MCO_RST_STAB_STS = 8'h00;
  localparam logic [7:0] MCO_RST_STAB_SEL = 8'h07;
  localparam logic [7:0] MCO_RST_CLK_SEL  = 8'h00;
  localparam logic [7:0] MCO_RD_UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // Stabilization waits in crystal cycles, indexed by wait select
  // ----------------------------------------------------------------
  localparam int          MCO_CNT_W = 19;
  localparam logic [18:0] MCO_WAIT_CYC [0:7] = '{
    19'h00100, 19'h00200, 19'h00400, 19'h00800,
    19'h02000, 19'h08000, 19'h20000, 19'h40000
  };

  // ----------------------------------------------------------------
  // Source switch timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MCO_QUIET_CYC = 2'h2;

  typedef enum logic [1:0] {
    MCO_SW_RUN   = 2'b00,
    MCO_SW_QUIET = 2'b01,
    MCO_SW_SWAP  = 2'b10
  } mco_sw_state_t;

endpackage

/* File: core/mco_sync2.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module mco_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

/* File: core/mco_stab_counter.sv */
// Crystal stabilization counter with progressive sticky status flags
`timescale 1ns/1ps
module mco_stab_counter (
  // Clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  // Control
  input  wire logic                            clear,
  input  wire logic                            run,
  input  wire logic                            xtal_tick,
  input  wire logic [mco_pkg::MCO_WAIT_SEL_W-1:0] wait_sel,
  // Status
  output logic      [7:0]                      flags,
  output logic                                 reached
);
  import mco_pkg::*;

  logic [MCO_CNT_W-1:0] count_ff;
  logic [MCO_CNT_W-1:0] nxt_count;
  logic [7:0]           flags_ff;
  logic [7:0]           nxt_flags;
  logic [MCO_CNT_W-1:0] limit;
  logic                 at_limit;
  logic                 step;

  // ----------------------------------------------------------------
  // Count control
  // ----------------------------------------------------------------
  assign limit     = MCO_WAIT_CYC[wait_sel];                  // [R19]
  assign at_limit  = (count_ff >= limit);                     // [R17]
  assign step      = run & xtal_tick & ~at_limit;             // [R15] [R22]
  assign nxt_count = clear ? '0 : (step ? count_ff + MCO_CNT_W'(1'b1) : count_ff);

  // Flag 7 marks the shortest wait, flag 0 the longest
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_flag
      assign nxt_flags[7-k] = ~clear & (flags_ff[7-k] | (count_ff >= MCO_WAIT_CYC[k])); // [R16]
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_ff <= '0;
      flags_ff <= MCO_RST_STAB_STS;                           // [R14]
    end else begin
      count_ff <= nxt_count;
      flags_ff <= nxt_flags;
    end
  end

  assign flags   = flags_ff;
  assign reached = at_limit;

endmodule

/* File: test/mco_xtal_model.sv */
// Partner model: crystal resonator or external clock at the high-speed pins
`timescale 1ns/1ps
module mco_xtal_model #(
  parameter int HALF_NS  = 125,
  parameter int START_NS = 1000
) (
  // Run request from the block
  input  wire logic enable,
  // Pin and count of real rising edges
  output logic      crystal_input,
  output int        edges
);
  initial begin
    crystal_input = 1'b0;
    edges = 0;
    forever begin
      wait (enable === 1'b1);
      // Dead time before the first cycle is not part of the wait
      #(START_NS);
      while (enable === 1'b1) begin
        #(HALF_NS) crystal_input = 1'b1;
        edges = edges + 1;
        #(HALF_NS) crystal_input = 1'b0;
      end
      // Pin stands still while stopped or ignored
      edges = 0;
    end
  end
endmodule

/* File: test/mco_main_clock_ctrl_sva.sv */
// Checker: port-level properties of the main clock control
`timescale 1ns/1ps
module mco_main_clock_ctrl_sva (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       resetn,
  // Register port
  input wire logic [mco_pkg::MCO_AW-1:0] reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [7:0]                 reg_rdata,
  // Settings and pin
  input wire logic                       stop_mode,
  input wire logic                       external_clock_pin_mode,
  input wire logic                       oscillator_pin_select,
  input wire logic                       onchip_raw_is_48mhz,
  input wire logic                       crystal_input,
  // Outputs
  input wire logic                       crystal_osc_enable,
  input wire logic                       ext_clock_accept,
  input wire logic                       onchip_fast_osc_enable,
  input wire logic                       fast_osc_halve,
  input wire logic                       main_clock_from_crystal,
  input wire logic                       main_clock_gate_en,
  input wire logic                       high_speed_clock_ready
);
  import mco_pkg::*;
  wire run_wr = reg_wr && (reg_addr == MCO_ADDR_RUN_CTRL);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_rd_idle;     !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_fstop;       run_wr && reg_wdata[0] |=> !onchip_fast_osc_enable; endproperty
  property p_xstop;       run_wr && reg_wdata[7] |=> !crystal_osc_enable && !ext_clock_accept;
  endproperty
  property p_ready_fall;  run_wr && reg_wdata[7] |=> ##1 !high_speed_clock_ready; endproperty
  property p_port;        !oscillator_pin_select |-> !crystal_osc_enable && !ext_clock_accept;
  endproperty
  property p_halve;       1'b1 |=> fast_osc_halve == $past(onchip_raw_is_48mhz); endproperty
  property p_swap;
    $fell(main_clock_gate_en) |-> (!main_clock_gate_en)[*3]
      ##1 (main_clock_gate_en && $changed(main_clock_from_crystal));
  endproperty
  property p_mux_gate;    $changed(main_clock_from_crystal) |-> $rose(main_clock_gate_en); endproperty
  property p_xtal_ready;  $rose(main_clock_from_crystal) |-> high_speed_clock_ready; endproperty
  a_rd_idle:    assert property (p_rd_idle)    else $error("read data outside read slot");
  a_fstop:      assert property (p_fstop)      else $error("fast osc runs after stop");
  a_xstop:      assert property (p_xstop)      else $error("crystal runs after stop");
  a_ready_fall: assert property (p_ready_fall) else $error("ready kept after stop");
  a_port:       assert property (p_port)       else $error("crystal runs in port mode");
  a_halve:      assert property (p_halve)      else $error("halve does not follow option");
  a_swap:       assert property (p_swap)       else $error("switch sequence wrong");
  a_mux_gate:   assert property (p_mux_gate)   else $error("mux moved outside gap");
  a_xtal_ready: assert property (p_xtal_ready) else $error("crystal used before ready");
  c_swap:  cover property ($fell(main_clock_gate_en));
  c_ready: cover property ($rose(high_speed_clock_ready));
  c_xtal:  cover property ($rose(main_clock_from_crystal));
endmodule

bind mco_main_clock_ctrl mco_main_clock_ctrl_sva mco_main_clock_ctrl_sva_i (.*);

/* File: test/testbench.sv */
// Testbench: registers, stabilization wait and source switching of the main clock control
`timescale 1ns/1ps
module testbench;
  import mco_pkg::*;
  logic              clk_sys, resetn, reg_wr, reg_rd, stop_mode, rd_q;
  logic [MCO_AW-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, v;
  logic              external_clock_pin_mode, oscillator_pin_select, onchip_raw_is_48mhz;
  logic              crystal_input, crystal_osc_enable, ext_clock_accept, onchip_fast_osc_enable;
  logic              fast_osc_halve, main_clock_from_crystal, main_clock_gate_en;
  logic              high_speed_clock_ready;
  logic [7:0]        exp_q[$];
  int                errors, n_compared, cyc, seed, edges;

  mco_main_clock_ctrl mco_main_clock_ctrl_i (.*);
  mco_xtal_model mco_xtal_model_i (.enable(crystal_osc_enable | ext_clock_accept),
    .crystal_input(crystal_input), .edges(edges));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [MCO_AW-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [MCO_AW-1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask

  // Waits for the usable flag, then, for nonzero n, checks how many real edges it took
  task automatic wait_ready(input int n);
    for (int i = 0; i < 6000 && high_speed_clock_ready !== 1'b1; i++) @(negedge clk_sys);
    check("high_speed_clock_ready", high_speed_clock_ready, 1'b1);
    if (n > 0) check("edges", (edges >= n) && (edges <= n + 1), 1'b1);
  endtask

  task automatic wait_mux(input logic x);
    for (int i = 0; i < 20 && main_clock_from_crystal !== x; i++) @(negedge clk_sys);
    check("main_clock_from_crystal", main_clock_from_crystal, x);
  endtask

  // Read data monitor and run limit
  always @(posedge clk_sys) begin
    if (rd_q) check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
    cyc++;
    if (cyc % 7 == 1) onchip_raw_is_48mhz <= 1'($random(seed));
    if (cyc == 30000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    {resetn, reg_wr, reg_rd, stop_mode, external_clock_pin_mode} = '0;
    {oscillator_pin_select, reg_wdata} = '0;
    reg_addr = '0;
    seed = 97;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    oscillator_pin_select <= 1'b1;
    rd(MCO_ADDR_RUN_CTRL, 8'hC0);
    rd(MCO_ADDR_STAB_STS, 8'h00);
    rd(MCO_ADDR_STAB_SEL, 8'h07);
    rd(MCO_ADDR_CLK_SEL, 8'h00);
    rd(20'hFFFA5, 8'h00);
    wr(MCO_ADDR_RUN_CTRL, 8'hBE);
    rd(MCO_ADDR_RUN_CTRL, 8'hC0);
    v = 8'($random(seed));
    wr(MCO_ADDR_STAB_SEL, v);
    rd(MCO_ADDR_STAB_SEL, {5'h00, v[2:0]});
    wr(MCO_ADDR_CLK_SEL, 8'h20);
    rd(MCO_ADDR_CLK_SEL, 8'h00);
    wr(MCO_ADDR_STAB_STS, 8'hFF);
    rd(MCO_ADDR_STAB_STS, 8'h00);
    wr(MCO_ADDR_STAB_SEL, 8'h00);
    wr(MCO_ADDR_RUN_CTRL, 8'h40);
    repeat (60) @(posedge clk_sys);
    rd(MCO_ADDR_STAB_STS, 8'h00);
    @(negedge clk_sys) check("high_speed_clock_ready", high_speed_clock_ready, 1'b0);
    wait_ready(256);
    rd(MCO_ADDR_STAB_STS, 8'h80);
    repeat (1500) @(posedge clk_sys);
    rd(MCO_ADDR_STAB_STS, 8'h80);
    wr(MCO_ADDR_CLK_SEL, 8'h10);
    wait_mux(1'b1);
    rd(MCO_ADDR_CLK_SEL, 8'h30);
    wr(MCO_ADDR_RUN_CTRL, 8'h41);
    @(negedge clk_sys);
    check("onchip_fast_osc_enable", onchip_fast_osc_enable, 1'b0);
    wr(MCO_ADDR_RUN_CTRL, 8'h40);
    wr(MCO_ADDR_CLK_SEL, 8'h00);
    wait_mux(1'b0);
    rd(MCO_ADDR_CLK_SEL, 8'h00);
    @(posedge clk_sys) stop_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check("onchip_fast_osc_enable", onchip_fast_osc_enable, 1'b0);
    rd(MCO_ADDR_STAB_STS, 8'h00);
    stop_mode <= 1'b0;
    wait_ready(0);
    rd(MCO_ADDR_STAB_STS, 8'h80);
    wr(MCO_ADDR_RUN_CTRL, 8'hC0);
    @(negedge clk_sys);
    check("crystal_osc_enable", crystal_osc_enable, 1'b0);
    rd(MCO_ADDR_STAB_STS, 8'h00);
    wr(MCO_ADDR_STAB_SEL, 8'h01);
    wr(MCO_ADDR_RUN_CTRL, 8'h40);
    wait_ready(512);
    rd(MCO_ADDR_STAB_STS, 8'hC0);
    wr(MCO_ADDR_RUN_CTRL, 8'hC0);
    external_clock_pin_mode <= 1'b1;
    wr(MCO_ADDR_RUN_CTRL, 8'h40);
    @(negedge clk_sys);
    check("ext_clock_accept", ext_clock_accept, 1'b1);
    check("crystal_osc_enable", crystal_osc_enable, 1'b0);
    @(posedge clk_sys) oscillator_pin_select <= 1'b0;
    @(negedge clk_sys);
    check("ext_clock_accept", ext_clock_accept, 1'b0);
    repeat (2) @(posedge clk_sys);
    finish_test();
  end
endmodule
